//--- rtl/ptt_pkg.sv
// constants and types shared by the periodic tick timer
package ptt_pkg;

  // register bus geometry
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam int          STRB_W       = 4;
  localparam int          BYTE_W       = 8;

  // register byte addresses
  localparam logic [7:0]  CTRL_OFS     = 8'h00;
  localparam logic [7:0]  PERIOD_OFS   = 8'h04;
  localparam logic [7:0]  CURRENT_OFS  = 8'h08;
  localparam logic [7:0]  STATUS_OFS   = 8'h0c;
  localparam logic [7:0]  MASK_OFS     = 8'h10;

  // control fields
  localparam int          CTRL_EN_BIT  = 0;
  localparam int          CTRL_IE_BIT  = 1;
  localparam int          CTRL_W       = 2;

  // status and mask fields
  localparam int          ST_TICK_BIT  = 0;
  localparam int          ST_ROLL_BIT  = 1;
  localparam int          ST_W         = 2;

  // counter and period widths, reset values
  localparam int          CNT_W        = 24;
  localparam int          PER_W        = 25;
  localparam logic [24:0] PERIOD_RESET = 25'h1000000;
  localparam logic [24:0] PERIOD_ONE   = 25'h0000001;
  localparam logic [23:0] CNT_ZERO     = 24'h000000;
  localparam logic [1:0]  CTRL_RESET   = 2'h0;
  localparam logic [1:0]  MASK_RESET   = 2'h3;

  // bus responses
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } ptt_wr_state_type;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } ptt_rd_state_type;

endpackage

//--- rtl/ptt_core.sv
// 24-bit down counter with deferred reload and rollover pulse
module ptt_core (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      enable,
  input  wire logic [ptt_pkg::PER_W-1:0] period,
  input  wire logic                      clear,
  output logic      [ptt_pkg::CNT_W-1:0] count,
  output logic                           rollover
);
  import ptt_pkg::*;

  logic [CNT_W-1:0] count_reg;
  logic             reload_reg;
  logic             rollover_reg;
  logic [CNT_W-1:0] period_m1;

  // wrap value is period minus one; 2^24 wraps to all ones
  assign period_m1 = CNT_W'(period - PERIOD_ONE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg  <= CNT_ZERO;
      reload_reg <= 1'b1;
    end else if (clear) begin
      count_reg  <= CNT_ZERO;  // see [RL4]
      reload_reg <= 1'b1;      // see [RL5]
    end else if (enable) begin
      // see [RL2] [RL6] [RL13]
      if (reload_reg || count_reg == CNT_ZERO) begin
        count_reg <= period_m1;
      end else begin
        count_reg <= count_reg - 1'b1;
      end
      reload_reg <= 1'b0;
    end
  end

  // forced reload is not a wrap, so it raises no tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rollover_reg <= 1'b0;
    end else begin
      // see [RL1] [RL8]
      rollover_reg <= enable && !clear && !reload_reg &&
                      count_reg == CNT_ZERO;
    end
  end

  assign count    = count_reg;
  assign rollover = rollover_reg;
endmodule

//--- rtl/ptt_irq.sv
// sticky event status, read clear and masked level interrupt
module ptt_irq (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic [ptt_pkg::ST_W-1:0] set_events,
  input  wire logic [ptt_pkg::ST_W-1:0] clear_events,
  input  wire logic [ptt_pkg::ST_W-1:0] mask,
  output logic      [ptt_pkg::ST_W-1:0] status,
  output logic                          irq
);
  import ptt_pkg::*;

  logic [ST_W-1:0] status_reg;
  logic [ST_W-1:0] status_next;
  logic            irq_reg;

  genvar i;
  generate
    for (i = 0; i < ST_W; i++) begin : g_bit
      // a new event beats a clear in the same cycle
      assign status_next[i] = set_events[i] |
                              (status_reg[i] & ~clear_events[i]);
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          status_reg[i] <= 1'b0;
        end else begin
          status_reg[i] <= status_next[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_next & mask);  // see [RL11]
    end
  end

  assign status = status_reg;
  assign irq    = irq_reg;
endmodule

//--- rtl/ptt_top.sv
// periodic tick timer with AXI4-Lite registers
//
// Notes on behaviour
// [RL1] Disabling halts the counter; no tick interrupt until enabled again.
// [RL2] Enabling resumes from the held count, without reloading the period.
// [RL3] Each rollover while enabled with interrupt on raises a tick request.
// [RL4] Any write to the current value clears count; next clock reloads.
// [RL5] Written while disabled, the reload happens on first enabled clock.
// [RL6] A new period applies only at the next wrap or forced reload.
// [RL7] Software programs period from 1 to 16,777,216 clocks inclusive.
// [RL8] Clocks between tick interrupts equal the programmed period.
// [RL9] Current value reads between period minus one and zero.
// [RL10] Handler entry clears the pending tick without software action. Only TICK clears; an unmasked ROLL bit holds tick_irq until a STATUS read.
// [RL11] Interrupt enable clear blocks ticks; set passes them to the core.
// [RL12] The programmed period reads back as written.
// [RL13] Counts down each clock, reloads period minus one at zero, 24 bits.
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
module ptt_top (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // write address channel
  input  wire logic [ptt_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                 s_axi_awprot,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  // write data channel
  input  wire logic [ptt_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [ptt_pkg::STRB_W-1:0] s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  // write response channel
  output logic      [1:0]                 s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // read address channel
  input  wire logic [ptt_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                 s_axi_arprot,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  // read data channel
  output logic      [ptt_pkg::DATA_W-1:0] s_axi_rdata,
  output logic      [1:0]                 s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // vector interrupt controller side
  input  wire logic                       tick_handler_entry,
  output logic                            tick_irq
);
  import ptt_pkg::*;

  // write path state
  ptt_wr_state_type    wr_state_reg;
  logic                awready_reg;
  logic                wready_reg;
  logic                aw_held_reg;
  logic                w_held_reg;
  logic [ADDR_W-1:0]   waddr_reg;
  logic [DATA_W-1:0]   wdata_reg;
  logic [STRB_W-1:0]   wstrb_reg;
  logic                bvalid_reg;
  logic [1:0]          bresp_reg;

  // read path state
  ptt_rd_state_type    rd_state_reg;
  logic                arready_reg;
  logic                rvalid_reg;
  logic [DATA_W-1:0]   rdata_reg;
  logic [1:0]          rresp_reg;

  // software visible control
  logic [CTRL_W-1:0]   ctrl_reg;
  logic [PER_W-1:0]    period_reg;
  logic [ST_W-1:0]     mask_reg;

  // block state
  logic [CNT_W-1:0]    count;
  logic                rollover;
  logic [ST_W-1:0]     status;
  logic                irq;

  // decode and strobes
  logic                aw_take;
  logic                w_take;
  logic                wr_fire;
  logic [ADDR_W-1:0]   waddr_word;
  logic                wr_hit;
  logic                wr_ctrl;
  logic                wr_period;
  logic                wr_current;
  logic                wr_mask;
  logic                ar_take;
  logic [ADDR_W-1:0]   raddr_word;
  logic                rd_hit;
  logic [DATA_W-1:0]   rd_value;
  logic                rd_status;
  logic                timer_en;
  logic                tick_ie;
  logic [ST_W-1:0]     set_events;
  logic [ST_W-1:0]     clear_events;
  logic [ST_W-1:0]     mask_eff;

  // merge write data into a word under byte strobes
  function automatic logic [DATA_W-1:0] merge_bytes(
    input logic [DATA_W-1:0] old_word,
    input logic [DATA_W-1:0] new_word,
    input logic [STRB_W-1:0] strb
  );
    logic [DATA_W-1:0] res;
    res = old_word;
    for (int b = 0; b < STRB_W; b++) begin
      if (strb[b]) begin
        res[b*BYTE_W +: BYTE_W] = new_word[b*BYTE_W +: BYTE_W];
      end
    end
    return res;
  endfunction

  assign timer_en = ctrl_reg[CTRL_EN_BIT];
  assign tick_ie  = ctrl_reg[CTRL_IE_BIT];

  // ---- write channel ----
  assign aw_take = s_axi_awvalid && awready_reg;
  assign w_take  = s_axi_wvalid && wready_reg;
  assign wr_fire = (wr_state_reg == WR_IDLE) && aw_held_reg && w_held_reg;

  assign waddr_word = {waddr_reg[ADDR_W-1:2], 2'b00};
  assign wr_ctrl    = wr_fire && waddr_word == CTRL_OFS;
  assign wr_period  = wr_fire && waddr_word == PERIOD_OFS;
  assign wr_current = wr_fire && waddr_word == CURRENT_OFS;
  assign wr_mask    = wr_fire && waddr_word == MASK_OFS;
  assign wr_hit     = waddr_word == CTRL_OFS || waddr_word == PERIOD_OFS ||
                      waddr_word == CURRENT_OFS || waddr_word == STATUS_OFS ||
                      waddr_word == MASK_OFS;

  // address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      waddr_reg   <= '0;
    end else if (aw_take) begin
      aw_held_reg <= 1'b1;
      waddr_reg   <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg  <= '0;
      wstrb_reg  <= '0;
    end else if (w_take) begin
      w_held_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata;
      wstrb_reg  <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
    end else if (aw_take) begin
      awready_reg <= 1'b0;
    end else begin
      awready_reg <= wr_state_reg == WR_IDLE && !aw_held_reg && !wr_fire;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_reg <= 1'b0;
    end else if (w_take) begin
      wready_reg <= 1'b0;
    end else begin
      wready_reg <= wr_state_reg == WR_IDLE && !w_held_reg && !wr_fire;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= WR_IDLE;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= RESP_OKAY;
    end else begin
      case (wr_state_reg)
        WR_IDLE: begin
          if (wr_fire) begin
            bvalid_reg   <= 1'b1;
            bresp_reg    <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            wr_state_reg <= WR_RESP;
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            bvalid_reg   <= 1'b0;
            wr_state_reg <= WR_IDLE;
          end
        end
        default: begin
          bvalid_reg   <= 1'b0;
          wr_state_reg <= WR_IDLE;
        end
      endcase
    end
  end

  // ---- software registers ----
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_ctrl) begin
      // see [RL1] [RL11]
      ctrl_reg <= CTRL_W'(merge_bytes(DATA_W'(ctrl_reg), wdata_reg,
                                      wstrb_reg));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_reg <= PERIOD_RESET;
    end else if (wr_period) begin
      // stored only; the counter picks it up at its next reload
      period_reg <= PER_W'(merge_bytes(DATA_W'(period_reg), wdata_reg,
                                       wstrb_reg));  // see [RL6] [RL7]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_reg <= MASK_RESET;
    end else if (wr_mask) begin
      mask_reg <= ST_W'(merge_bytes(DATA_W'(mask_reg), wdata_reg,
                                    wstrb_reg));
    end
  end

  // ---- read channel ----
  assign ar_take    = s_axi_arvalid && arready_reg;
  assign raddr_word = {s_axi_araddr[ADDR_W-1:2], 2'b00};
  assign rd_status  = ar_take && raddr_word == STATUS_OFS;

  always_comb begin
    rd_hit   = 1'b1;
    rd_value = '0;
    case (raddr_word)
      CTRL_OFS:    rd_value = DATA_W'(ctrl_reg);
      PERIOD_OFS:  rd_value = DATA_W'(period_reg);  // see [RL12]
      CURRENT_OFS: rd_value = DATA_W'(count);       // see [RL9]
      STATUS_OFS:  rd_value = DATA_W'(status);
      MASK_OFS:    rd_value = DATA_W'(mask_reg);
      default:     rd_hit   = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_reg <= RD_IDLE;
      arready_reg  <= 1'b0;
      rvalid_reg   <= 1'b0;
      rdata_reg    <= '0;
      rresp_reg    <= RESP_OKAY;
    end else begin
      case (rd_state_reg)
        RD_IDLE: begin
          if (ar_take) begin
            arready_reg  <= 1'b0;
            rvalid_reg   <= 1'b1;
            rdata_reg    <= rd_value;
            rresp_reg    <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rd_state_reg <= RD_DATA;
          end else begin
            arready_reg <= 1'b1;
          end
        end
        RD_DATA: begin
          if (s_axi_rready) begin
            rvalid_reg   <= 1'b0;
            rd_state_reg <= RD_IDLE;
          end
        end
        default: begin
          arready_reg  <= 1'b0;
          rvalid_reg   <= 1'b0;
          rd_state_reg <= RD_IDLE;
        end
      endcase
    end
  end

  // ---- counter ----
  ptt_core u_core (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .enable   (timer_en),    // see [RL1] [RL2] [RL5]
    .period   (period_reg),
    .clear    (wr_current),  // see [RL4]
    .count    (count),
    .rollover (rollover)
  );

  // ---- events and interrupt ----
  always_comb begin
    set_events              = '0;
    set_events[ST_TICK_BIT] = rollover && tick_ie;  // see [RL3] [RL11]
    set_events[ST_ROLL_BIT] = rollover;
  end

  always_comb begin
    clear_events = {ST_W{rd_status}};
    // handler entry drops the pending tick by itself
    if (tick_handler_entry) begin
      clear_events[ST_TICK_BIT] = 1'b1;  // see [RL10]
    end
  end

  // nothing reaches the core while stopped or with tick interrupts off
  assign mask_eff = mask_reg & {ST_W{timer_en && tick_ie}};  // see [RL11]

  ptt_irq u_irq (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .set_events   (set_events),
    .clear_events (clear_events),
    .mask         (mask_eff),
    .status       (status),
    .irq          (irq)
  );

  // ---- outputs ----
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign tick_irq      = irq;  // see [RL3] [RL8]

endmodule

//--- test/ptt_chk_sva.sv
// port checks for the periodic tick timer
module ptt_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        tick_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  import ptt_pkg::*;
  logic       wr_hs, rd_hs;
  logic [1:0] ctl_reg;
  assign wr_hs = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
  assign rd_hs = s_axi_arvalid & s_axi_arready;
  // enable and interrupt enable bits as last written
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_reg <= 2'h0;
    end else if (wr_hs && s_axi_awaddr[7:2] == 6'h00) begin
      ctl_reg <= s_axi_wdata[1:0];
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  write_answer_a: assert property (wr_hs |-> ##2 s_axi_bvalid)
    else $error("no write response");
  read_answer_a: assert property (rd_hs |=> s_axi_rvalid)
    else $error("no read data");
  write_busy_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  bad_write_a: assert property (wr_hs && s_axi_awaddr > 8'h13 |-> ##2
    s_axi_bresp == RESP_SLVERR) else $error("unmapped write not refused");
  bad_read_a: assert property (rd_hs && s_axi_araddr > 8'h13 |=>
    s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  irq_halted_a: assert property (!ctl_reg[0] [*3] |-> !tick_irq)
    else $error("interrupt while disabled");
  irq_ie_off_a: assert property (!ctl_reg[1] [*3] |-> !tick_irq)
    else $error("interrupt with tick interrupts off");
  cover property ($rose(tick_irq));
  cover property (wr_hs && s_axi_awaddr > 8'h13);
  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule

bind ptt_top ptt_chk i_ptt_chk (.*);

//--- test/ptt_cpu_model.sv
// processor side: enters the tick handler a set time after the request
module ptt_cpu_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       tick_irq,
  input  wire logic [3:0] delay,
  output logic            tick_handler_entry
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_reg;
  logic [1:0] skip_reg;
  always_ff @(posedge aclk) begin
    tick_handler_entry <= 1'b0;
    if (!aresetn || !tick_irq) begin
      wait_reg <= 4'h0;
      skip_reg <= 2'h0;
    end else if (skip_reg != 2'h0) begin
      // request stays up for an edge after entry
      skip_reg <= skip_reg - 2'h1;
    end else if (wait_reg == delay) begin
      tick_handler_entry <= 1'b1;
      wait_reg           <= 4'h0;
      skip_reg           <= 2'h2;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule

//--- test/ptt_top_tb.sv
// self-checking bench for the periodic tick timer
module ptt_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ptt_pkg::*;
  logic        aclk, aresetn, tick_handler_entry, tick_irq, irq_q;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, bresp_q, rresp_q;
  logic [3:0]  s_axi_wstrb, cpu_delay;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          seed, mismatches, tests_run, cyc, b_cyc;
  int          rise_q[$];

  ptt_top       i_ptt_top (.*);
  ptt_cpu_model i_ptt_cpu_model (.*, .delay(cpu_delay));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // cycle count and interrupt rising edges
  always @(posedge aclk) begin
    cyc   <= cyc + 1;
    irq_q <= tick_irq;
    if (tick_irq && !irq_q) rise_q.push_back(cyc);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("mismatches %0d, checks %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    bresp_q = 32'(s_axi_bresp);
    b_cyc   = cyc;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d       = s_axi_rdata;
    rresp_q = 32'(s_axi_rresp);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    check(d, e);
  endtask

  task automatic wait_rises(input int k);
    while (rise_q.size() < k) @(posedge aclk);
  endtask

  // cycles from write answer to interrupt seen, for a held count
  function automatic int gap(input int held);
    return held + 2;
  endfunction

  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    give_verdict();
  end

  initial begin
    logic [31:0] v, p, q;
    int n;
    seed = 75159;
    mismatches = 0;
    tests_run = 0;
    cyc = 0;
    irq_q = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_awprot = 3'h0;
    s_axi_arprot = 3'h0;
    s_axi_wstrb = 4'hf;
    cpu_delay = 4'h0;
    do_reset();
    rc(CTRL_OFS, 32'h0);
    rc(PERIOD_OFS, 32'h1000000);
    rc(MASK_OFS, 32'h3);
    rc(STATUS_OFS, 32'h0);
    rc(CURRENT_OFS, 32'h0);
    wr(8'h14, $random(seed));
    check(bresp_q, 32'(RESP_SLVERR));
    rc(8'hfc, 32'h0);
    check(rresp_q, 32'(RESP_SLVERR));
    rc(CTRL_OFS, 32'h0);
    for (n = 0; n < 6; n++) begin
      p = {$random(seed)} % 32'h1000000 + 1;
      if (n < 2) p = n == 0 ? 32'h1 : 32'h1000000;
      wr(PERIOD_OFS, p);
      rc(PERIOD_OFS, p);
    end
    p = 6 + {$random(seed)} % 8;
    wr(PERIOD_OFS, p);
    wr(MASK_OFS, 32'h1);
    wr(CURRENT_OFS, $random(seed));
    rc(CURRENT_OFS, 32'h0);
    cpu_delay <= 4'({$random(seed)} % 2);
    rise_q.delete();
    wr(CTRL_OFS, 32'h3);
    wait_rises(4);
    check(rise_q[0] - b_cyc, gap(p));
    for (n = 1; n < 4; n++) begin
      check(rise_q[n] - rise_q[n-1], p);
    end
    repeat (6) begin
      repeat ({$random(seed)} % 7) @(posedge aclk);
      rd(CURRENT_OFS, v);
      check(v < p, 1);
    end
    q = 6 + {$random(seed)} % 8;
    n = rise_q.size();
    wait_rises(n + 1);
    wr(PERIOD_OFS, q);
    wait_rises(n + 3);
    check(rise_q[n+1] - rise_q[n], p);
    check(rise_q[n+2] - rise_q[n+1], q);
    repeat ({$random(seed)} % q) @(posedge aclk);
    wr(CTRL_OFS, 32'h2);
    rd(CURRENT_OFS, v);
    repeat (2 * q) @(posedge aclk);
    rc(CURRENT_OFS, v);
    check(tick_irq, 1'b0);
    rd(STATUS_OFS, p);
    rise_q.delete();
    wr(CTRL_OFS, 32'h3);
    wait_rises(1);
    check(rise_q[0] - b_cyc, gap(v));
    // raw rollover unmasked too: tick interrupt off must still block it
    wr(MASK_OFS, 32'h3);
    wr(CTRL_OFS, 32'h1);
    rd(STATUS_OFS, v);
    repeat (3 * q) @(posedge aclk);
    check(tick_irq, 1'b0);
    rc(STATUS_OFS, 32'h2);
    wr(MASK_OFS, 32'h0);
    wr(CTRL_OFS, 32'h3);
    repeat (3 * q) @(posedge aclk);
    check(tick_irq, 1'b0);
    rc(STATUS_OFS, 32'h3);
    // stop, clear and count rises from a quiet start
    wr(CTRL_OFS, 32'h0);
    wr(MASK_OFS, 32'h2);
    rd(STATUS_OFS, v);
    n = rise_q.size();
    wr(CTRL_OFS, 32'h3);
    wait_rises(n + 1);
    rd(STATUS_OFS, v);
    check(v[ST_ROLL_BIT], 1'b1);
    @(posedge aclk);
    check(tick_irq, 1'b0);
    do_reset();
    check(tick_irq, 1'b0);
    rc(CTRL_OFS, 32'h0);
    give_verdict();
  end
endmodule
